// file: src/shift_rate_gen.v
// Shift clock phase tick generator
`timescale 1ns/1ps
module shift_rate_gen (
  input wire clk_in,
  input wire rstn_in,
  input wire timer_baud_select_in,
  input wire rate_double_select_in,
  input wire compat_timing_in,
  input wire timer1_overflow_in,
  input wire run_in,
  output reg phase_tick_out
);
`include "sync_shift_map.vh"
  // ----------------------------------------
  // Half period length in source ticks
  // ----------------------------------------
  reg [`CNT_W-1:0] half_len;
  reg [`CNT_W-1:0] count;
  reg odd_half;
  wire src_tick;
  assign src_tick = timer_baud_select_in ? timer1_overflow_in : 1'b1;
  always @* begin
    if (timer_baud_select_in) begin
      half_len = rate_double_select_in ? `DIV_T1_DBL : `DIV_T1_SLOW;
    end else if (compat_timing_in) begin
      // Divide by 3 has uneven halves: 2 then 1 clock
      if (rate_double_select_in) begin
        half_len = odd_half ? `CNT_ONE : `DIV_COMPAT_DBL_HALF;
      end else begin
        half_len = `DIV_COMPAT_SLOW;
      end
    end else begin
      half_len = rate_double_select_in ? `DIV_FAST_DBL : `DIV_FAST_SLOW;
    end
  end
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count <= `CNT_ZERO;
      odd_half <= 1'b0;
      phase_tick_out <= 1'b0;
    end else begin
      phase_tick_out <= 1'b0;
      if (!run_in) begin
        // Free phase reference restarts so a transfer starts within one bit slot
        count <= `CNT_ZERO;
        odd_half <= 1'b0;
      end else if (src_tick) begin
        if (count + `CNT_ONE >= half_len) begin
          count <= `CNT_ZERO;
          odd_half <= ~odd_half;
          phase_tick_out <= 1'b1;
        end else begin
          count <= count + `CNT_ONE;
        end
      end
    end
  end
endmodule

// file: src/sync_shift_map.vh
// Constants for the synchronous shift mode serial port
`ifndef SYNC_SHIFT_MAP_VH
`define SYNC_SHIFT_MAP_VH
`define DATA_W 8
`define TX_SR_W 9
`define TX_LOAD_MARK 1'b1
`define RX_SR_INIT 8'hfe
`define BITS_PER_BYTE 4'h8
`define DIV_FAST_SLOW 3'h2
`define DIV_FAST_DBL 3'h1
`define DIV_COMPAT_SLOW 3'h3
`define DIV_COMPAT_DBL 3'h3
`define DIV_T1_SLOW 3'h2
`define DIV_T1_DBL 3'h1
`define CNT_W 3
`define CNT_ONE 3'h1
`define CNT_ZERO 3'h0
`define DIV_COMPAT_DBL_HALF 3'h2
`endif

// file: src/sync_shift_port.v
// Synchronous shift mode serial port, two-wire and three-wire
`timescale 1ns/1ps
module sync_shift_port (
  input wire clk_in,
  input wire rstn_in,
  input wire three_wire_enable_in,
  input wire timer_baud_select_in,
  input wire rate_double_select_in,
  input wire clock_idle_select_in,
  input wire compat_timing_in,
  input wire timer1_overflow_in,
  input wire rx_enable_in,
  input wire serial_buffer_write_in,
  input wire [7:0] serial_buffer_wdata_in,
  input wire tx_done_clear_in,
  input wire rx_done_clear_in,
  input wire port3_bit0_latch_in,
  input wire port3_bit0_in,
  input wire port1_bit6_in,
  output wire port3_bit0_out,
  output wire port3_bit0_oe_out,
  output wire port3_bit1_out,
  output wire port1_bit5_out,
  output wire port1_bit5_oe_out,
  output wire port1_bit7_out,
  output wire port1_bit7_oe_out,
  output reg [7:0] serial_buffer_out,
  output reg tx_done_flag_out,
  output reg rx_done_flag_out,
  output reg tx_phase_out,
  output reg rx_phase_out
);
`include "sync_shift_map.vh"
  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_LOW = 2'b01;
  localparam ST_HIGH = 2'b10;
  localparam ST_RX_PREP = 2'b11;
  reg [1:0] state;
  reg [1:0] next_state;
  reg [`TX_SR_W-1:0] tx_sr;
  reg [`DATA_W-1:0] rx_sr;
  reg tx_pending;
  reg rx_armed;
  reg sclk;
  reg data_bit;
  wire phase_tick;
  wire busy;
  wire rx_start;
  wire sample_now;
  wire change_now;
  wire rx_in_bit;
  wire idle_level;
  wire tx_last;
  wire rx_last;
  wire lead_change;
  wire lead_sample;
  wire [`DATA_W-2:0] rx_rev;
  reg rx_captured;
  assign busy = tx_phase_out | rx_phase_out;
  assign idle_level = ~clock_idle_select_in;
  assign rx_start = ~three_wire_enable_in & rx_enable_in & ~rx_done_flag_out
                    & ~busy & ~tx_pending & (state == ST_IDLE);
  // Only the synchronous data pin is sampled; no start detection exists here
  assign rx_in_bit = three_wire_enable_in ? port1_bit6_in : port3_bit0_in;
  assign tx_last = (tx_sr[`TX_SR_W-1:1] == 8'h01);
  assign rx_last = ~rx_sr[`DATA_W-1];
  // First bit in ends up leftmost, so the byte is read back in reverse
  genvar g;
  generate
    for (g = 0; g < `DATA_W - 1; g = g + 1) begin : g_rev
      assign rx_rev[g] = rx_sr[`DATA_W - 2 - g];
    end
  endgenerate
  // ----------------------------------------
  // Rate generator
  // ----------------------------------------
  shift_rate_gen u_rate (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .timer_baud_select_in(timer_baud_select_in),
    .rate_double_select_in(rate_double_select_in),
    .compat_timing_in(compat_timing_in),
    .timer1_overflow_in(timer1_overflow_in),
    .run_in(tx_pending | busy | (state == ST_RX_PREP)),
    .phase_tick_out(phase_tick)
  );
  // ----------------------------------------
  // Clock edges: first half leaves idle, second returns
  // ----------------------------------------
  // Idle high: first half high, falling at end. Idle low: first half low, rising.
  // Rate clear: data changes at idle, sampled at the return edge.
  // Rate set: data changes on falling, sampled on rising.
  // Idle high, rate set: data moves on the leaving (falling) edge instead
  assign lead_change = rate_double_select_in & ~clock_idle_select_in;
  // Idle low, rate set: the leaving edge is the rising, sampling one
  assign lead_sample = rate_double_select_in & clock_idle_select_in;
  assign sample_now = phase_tick & rx_phase_out & (
    lead_sample ? (state == ST_LOW) : (state == ST_HIGH));
  // The register always advances on the return edge; only the pin timing moves
  assign change_now = phase_tick & tx_phase_out & (state == ST_HIGH);
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (tx_pending & phase_tick) begin
          next_state = ST_LOW;
        end else if (rx_start) begin
          next_state = ST_RX_PREP;
        end
      end
      ST_RX_PREP: begin
        if (phase_tick) begin
          next_state = ST_LOW;
        end
      end
      ST_LOW: begin
        if (phase_tick) begin
          next_state = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (phase_tick) begin
          next_state = ((tx_phase_out & tx_last)
                        | (rx_phase_out & (rx_captured | (sample_now & rx_last))))
                       ? ST_IDLE : ST_LOW;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ST_IDLE;
      tx_sr <= {`TX_SR_W{1'b0}};
      rx_sr <= {`DATA_W{1'b1}};
      tx_pending <= 1'b0;
      rx_armed <= 1'b0;
      rx_captured <= 1'b0;
      sclk <= 1'b1;
      data_bit <= 1'b1;
      serial_buffer_out <= 8'h00;
      tx_done_flag_out <= 1'b0;
      rx_done_flag_out <= 1'b0;
      tx_phase_out <= 1'b0;
      rx_phase_out <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_IDLE) begin
        sclk <= idle_level;
      end else if (phase_tick & (state != ST_RX_PREP)) begin
        sclk <= ~sclk;
      end
      if (serial_buffer_write_in & ~busy) begin
        tx_sr <= {`TX_LOAD_MARK, serial_buffer_wdata_in};
        tx_pending <= 1'b1;
        rx_armed <= three_wire_enable_in & rx_enable_in;
        if (three_wire_enable_in & rx_enable_in) begin
          rx_sr <= `RX_SR_INIT;
        end
      end
      if (state == ST_IDLE && tx_pending && phase_tick) begin
        tx_pending <= 1'b0;
        tx_phase_out <= 1'b1;
        rx_phase_out <= rx_armed;
        data_bit <= tx_sr[0];
      end
      if (rx_start) begin
        rx_sr <= `RX_SR_INIT;
      end
      if (state == ST_RX_PREP && phase_tick) begin
        rx_phase_out <= 1'b1;
      end
      if (change_now) begin
        tx_sr <= {1'b0, tx_sr[`TX_SR_W-1:1]};
        if (!lead_change) begin
          data_bit <= tx_sr[1];
        end
      end
      if (phase_tick & tx_phase_out & lead_change & (state == ST_LOW)) begin
        data_bit <= tx_sr[0];
      end
      if (sample_now) begin
        rx_sr <= {rx_sr[`DATA_W-2:0], rx_in_bit};
        if (rx_last) begin
          // Marker at the left end: this is the final shift
          serial_buffer_out <= {rx_in_bit, rx_rev};
          rx_captured <= 1'b1;
        end
      end
      if (state == ST_HIGH && next_state == ST_IDLE) begin
        tx_phase_out <= 1'b0;
        rx_phase_out <= 1'b0;
        data_bit <= 1'b1;
        rx_captured <= 1'b0;
        if (tx_phase_out) begin
          tx_done_flag_out <= 1'b1;
        end
        if (rx_phase_out) begin
          rx_done_flag_out <= 1'b1;
        end
      end else begin
        if (tx_done_clear_in) begin
          tx_done_flag_out <= 1'b0;
        end
        if (rx_done_clear_in) begin
          rx_done_flag_out <= 1'b0;
        end
      end
    end
  end
  // ----------------------------------------
  // Pin routing
  // ----------------------------------------
  // Two-wire: port3_bit0 carries data, port3_bit1 carries the clock
  assign port3_bit0_out = (~three_wire_enable_in & tx_phase_out)
                          ? data_bit : port3_bit0_latch_in;
  assign port3_bit0_oe_out = ~(~three_wire_enable_in & rx_phase_out)
                             & (tx_phase_out | ~port3_bit0_latch_in);
  assign port3_bit1_out = three_wire_enable_in ? 1'b1 : sclk;
  assign port1_bit5_out = data_bit;
  assign port1_bit5_oe_out = three_wire_enable_in & tx_phase_out;
  assign port1_bit7_out = sclk;
  assign port1_bit7_oe_out = three_wire_enable_in;
endmodule

// file: testbench/shift_slave.sv
// Far-side shift register model
`timescale 1ns/1ps
module shift_slave (
  input wire sclk_in,
  input wire fall_in,
  input wire mosi_in,
  input wire load_in,
  input wire [7:0] reply_in,
  output reg miso_out,
  output reg [7:0] got_out,
  output reg [3:0] nbits_out
);
  // Sample on rising, or falling when idle low with rate clear
  wire edge_clk = sclk_in ^ fall_in;
  always @(posedge edge_clk or posedge load_in) begin
    if (load_in) begin
      got_out <= 8'h00;
      nbits_out <= 4'h0;
    end else begin
      got_out <= {mosi_in, got_out[7:1]};
      nbits_out <= nbits_out + 4'h1;
    end
  end
  // After the byte the line shows the inverse, never a stale bit
  always @(negedge edge_clk or posedge load_in) begin
    if (load_in) miso_out <= reply_in[0];
    else if (nbits_out < 4'h8) miso_out <= reply_in[nbits_out[2:0]];
    else miso_out <= !miso_out;
  end
endmodule

// file: testbench/sync_shift_port_props.sv
// Checker for the synchronous shift port
`timescale 1ns/1ps
module sync_shift_port_props (
  input wire clk_in,
  input wire rstn_in,
  input wire three_wire_enable_in,
  input wire clock_idle_select_in,
  input wire rx_enable_in,
  input wire serial_buffer_write_in,
  input wire tx_done_clear_in,
  input wire rx_done_clear_in,
  input wire port3_bit1_out,
  input wire port1_bit7_out,
  input wire [7:0] serial_buffer_out,
  input wire tx_done_flag_out,
  input wire rx_done_flag_out,
  input wire tx_phase_out,
  input wire rx_phase_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  wire idle = !tx_phase_out && !rx_phase_out;
  wire sclk = three_wire_enable_in ? port1_bit7_out : port3_bit1_out;
  a_idle_clock_level: assert property ((idle && $stable(clock_idle_select_in))[*3]
    |-> sclk == !clock_idle_select_in) else $error("clock off idle level");
  a_write_starts_tx: assert property (serial_buffer_write_in && idle
    |-> ##[1:8] tx_phase_out) else $error("write did not start send");
  a_tx_done_sets: assert property ($fell(tx_phase_out) |-> ##[0:1] tx_done_flag_out)
    else $error("send done not set");
  a_rx_done_sets: assert property ($fell(rx_phase_out) |-> ##[0:1] rx_done_flag_out)
    else $error("receive done not set");
  a_tx_flag_holds: assert property (tx_done_flag_out && !tx_done_clear_in |=> tx_done_flag_out)
    else $error("send done lost");
  a_rx_flag_holds: assert property (rx_done_flag_out && !rx_done_clear_in |=> rx_done_flag_out)
    else $error("receive done lost");
  a_rx_off_quiet: assert property (three_wire_enable_in && !rx_enable_in && !rx_phase_out
    |-> !$rose(rx_done_flag_out) && $stable(serial_buffer_out)) else $error("disabled rx acted");
  a_rx_auto_start: assert property (!three_wire_enable_in && rx_enable_in && !rx_done_flag_out
    && idle && !$past(rx_phase_out) && !serial_buffer_write_in |-> ##[1:8] rx_phase_out)
    else $error("receive did not start");
  c_tx_end: cover property ($fell(tx_phase_out));
  c_rx_two_wire: cover property (!three_wire_enable_in && $fell(rx_phase_out));
  c_idle_low: cover property (clock_idle_select_in && $fell(tx_phase_out));
endmodule
bind sync_shift_port sync_shift_port_props sync_shift_port_props_inst (.*);

// file: testbench/tb_sync_shift_port.sv
// Self-checking bench for the synchronous shift port
`timescale 1ns/1ps
module tb_sync_shift_port;
  reg clk_in = 1'b0, rstn_in = 1'b0, tw = 1'b1, tbs = 1'b0, dbl = 1'b1, cis = 1'b0, cmp = 1'b0;
  reg t1ov = 1'b0, rxen = 1'b1, wr = 1'b0, txclr = 1'b0, rxclr = 1'b0, load = 1'b1;
  reg [7:0] wdata = 8'h00, reply = 8'h00;
  reg [1:0] ovc = 2'h0;
  wire p30, p30oe, p31, p15, p17, miso, txd, rxd, txp, rxp;
  wire [7:0] serial_buffer, got;
  wire [3:0] nbits;
  wire line = p30oe ? p30 : (tw | !rxen | miso);
  // Data may move on the same clock as the sampling edge; the slave sees it late
  wire #1 mosi_dly = tw ? p15 : line;
  integer errors = 0, n_tests = 0, cyc = 0, len = 0, i, k;
  integer exp_len [0:5] = '{32, 16, 48, 24, 96, 48};
  sync_shift_port sync_shift_port_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .three_wire_enable_in(tw), .timer_baud_select_in(tbs), .rate_double_select_in(dbl),
    .clock_idle_select_in(cis), .compat_timing_in(cmp), .timer1_overflow_in(t1ov),
    .rx_enable_in(rxen), .serial_buffer_write_in(wr), .serial_buffer_wdata_in(wdata),
    .tx_done_clear_in(txclr), .rx_done_clear_in(rxclr), .port3_bit0_latch_in(1'b1),
    .port3_bit0_in(line), .port1_bit6_in(miso), .port3_bit0_out(p30),
    .port3_bit0_oe_out(p30oe), .port3_bit1_out(p31), .port1_bit5_out(p15),
    .port1_bit5_oe_out(), .port1_bit7_out(p17), .port1_bit7_oe_out(),
    .serial_buffer_out(serial_buffer), .tx_done_flag_out(txd), .rx_done_flag_out(rxd),
    .tx_phase_out(txp), .rx_phase_out(rxp));
  shift_slave shift_slave_inst (.sclk_in(tw ? p17 : p31), .fall_in(cis & !dbl),
    .mosi_in(mosi_dly), .load_in(load), .reply_in(reply), .miso_out(miso),
    .got_out(got), .nbits_out(nbits));
  always #2 clk_in = !clk_in;
  always @(posedge clk_in) begin
    ovc <= (ovc == 2'h2) ? 2'h0 : ovc + 2'h1;
    t1ov <= (ovc == 2'h2);
    cyc <= cyc + 1;
    if (txp) len <= len + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      tally_and_finish;
    end
  end
  task check(input string what, input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task load_slave(input [7:0] r);
    begin
      reply <= r;
      load <= 1'b1;
      @(posedge clk_in);
      load <= 1'b0;
    end
  endtask
  // A second write mid-transfer must be ignored
  task xfer(input [7:0] d, input again);
    begin
      len = 0;
      wr <= 1'b1;
      wdata <= d;
      @(posedge clk_in);
      wr <= 1'b0;
      repeat (4) @(posedge clk_in);
      wr <= again;
      wdata <= 8'h00;
      @(posedge clk_in);
      wr <= 1'b0;
      i = 0;
      while (!(txd === 1'b1 && (rxd === 1'b1 || !rxen || !tw)) && i < 1000) begin
        @(posedge clk_in);
        i = i + 1;
      end
      check("sent byte", got, d);
      check("bit count", {4'h0, nbits}, 8'h08);
      txclr <= 1'b1;
      rxclr <= 1'b1;
      @(posedge clk_in);
      txclr <= 1'b0;
      rxclr <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    check("flags", {6'h0, txd, rxd}, 8'h00);
    check("buffer", serial_buffer, 8'h00);
    for (k = 0; k < 6; k = k + 1) begin
      tbs <= (k >= 4);
      dbl <= k[0];
      cmp <= (k == 2 || k == 3 || k == 5);
      cis <= (k == 1 || k == 2 || k == 5);
      repeat (5) @(posedge clk_in);
      check("idle clock", {7'h0, p17}, {7'h0, !cis});
      load_slave(8'hc3 + k[7:0]);
      xfer(8'h5a ^ k[7:0], k == 1);
      check("rate", {7'h0, len >= exp_len[k] - 1 && len <= exp_len[k] + 1}, 8'h01);
      check("received", serial_buffer, 8'hc3 + k[7:0]);
    end
    rxen <= 1'b0;
    load_slave(8'h77);
    xfer(8'h81, 1'b0);
    check("rx off buffer", serial_buffer, 8'hc8);
    tw <= 1'b0;
    dbl <= 1'b1;
    repeat (5) @(posedge clk_in);
    check("two-wire idle", {7'h0, p31}, {7'h0, !cis});
    load_slave(8'h00);
    xfer(8'h96, 1'b0);
    load_slave(8'h3b);
    rxen <= 1'b1;
    i = 0;
    while (rxd !== 1'b1 && i < 1000) begin
      @(posedge clk_in);
      i = i + 1;
    end
    check("two-wire rx", serial_buffer, 8'h3b);
    repeat (20) @(posedge clk_in);
    check("no restart", {7'h0, rxp}, 8'h00);
    tally_and_finish;
  end
endmodule
